// File: usb_token_flag_status_block_tb_top.sv
// self-checking bench for the usb interface status block
// assumes usbif_xcvr_model on the line side and a 200 MHz ref_clk
`timescale 1ns/1ps
`default_nettype none
module usb_token_flag_status_block_tb_top;
    logic                  ref_clk, reset_n;
    usbif_pkg::usbif_req_s reg_req;
    usbif_pkg::usbif_rsp_s reg_rsp;
    logic                  packet_start, token_ok, crc16_fail, pid_strobe, token_strobe;
    logic                  sof_strobe, act_cmd, err_cmd, auto_resume_se0, auto_resume_k;
    logic                  receive_active_input, receive_error_input;
    logic [1:0]            line_state_raw, line_cmd, line_state_filt;
    logic [3:0]            pid_in, token_endpoint;
    logic [10:0]           sof_frame;
    logic                  notify_port_n, notify_port_o, notify_port_p, notify_port_q;
    logic [4:0]            rx_endpoint;
    logic                  rx_endpoint_valid, pulldown_disable, suspend_ctl_enable;
    logic [2:0]            transceiver_config_pins;
    int                    num_errors, n_checks;
    int                    seed = 32'h2d28_26a5;
    logic [7:0]            offs [10] = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38,
                                         8'h3c, 8'h40, 8'h44};
    logic [31:0]           msk [10] = '{32'h7f, 32'hffff_ffff, 32'h7ff, 32'h0, 32'h0,
                                        32'hffff, 32'hffff_ffff, 32'h1ff, 32'h0004_3ff0, 32'h0};

    usbif_status_block u_usbif_status_block (
        .ref_clk, .reset_n, .reg_req, .reg_rsp, .packet_start, .token_ok, .crc16_fail,
        .receive_active_input, .receive_error_input, .line_state_raw, .pid_strobe, .pid_in,
        .token_strobe, .token_endpoint, .sof_strobe, .sof_frame, .auto_resume_se0,
        .auto_resume_k, .notify_port_n, .notify_port_o, .notify_port_p, .notify_port_q,
        .rx_endpoint, .rx_endpoint_valid, .line_state_filt, .pulldown_disable,
        .suspend_ctl_enable, .transceiver_config_pins
    );
    usbif_xcvr_model u_usbif_xcvr_model (
        .ref_clk, .reset_n, .suspend_ctl_enable, .line_cmd, .act_cmd, .err_cmd,
        .line_state_raw, .receive_active_input, .receive_error_input, .auto_resume_se0,
        .auto_resume_k
    );

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge ref_clk);
        reg_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string nm);
        @(posedge ref_clk);
        reg_req <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge ref_clk);
        reg_req.rd <= 1'b0;
        #1;
        chk({nm, " rvalid"}, 32'h1, {31'h0, reg_rsp.rvalid});
        chk(nm, e, reg_rsp.rdata & m);
    endtask
    // s is {packet_start, crc16_fail, token_ok}; clr adds a same-cycle clear of flags 6 and 2
    task automatic strobe(input logic [2:0] s, input logic clr);
        @(posedge ref_clk);
        {packet_start, crc16_fail, token_ok} <= s;
        if (clr) reg_req <= '{1'b1, 1'b0, 8'h1c, 32'h44};
        @(posedge ref_clk);
        {packet_start, crc16_fail, token_ok} <= 3'h0;
        reg_req.wr <= 1'b0;
    endtask
    task automatic chk_notify(input logic [3:0] e);
        chk("notify", {28'h0, e}, {28'h0, notify_port_n, notify_port_o, notify_port_p,
                                   notify_port_q});
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        $display("MISMATCH watchdog expected done seen timeout");
        summarize();
    end

    initial begin
        logic [31:0] v;
        logic [31:0] e;
        int          first;
        reset_n = 1'b0;
        reg_req = '0;
        {packet_start, token_ok, crc16_fail, pid_strobe, token_strobe, sof_strobe} = '0;
        {pid_in, token_endpoint, sof_frame, act_cmd, err_cmd} = '0;
        line_cmd = usbif_pkg::LINE_J;
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rd(offs[i], 32'hffff_ffff, 32'h0, "reset value");
            v = $random(seed);
            wr(offs[i], v);
            rd(offs[i], 32'hffff_ffff, v & msk[i], "read back");
        end
        wr(8'h40, 32'h0);
        wr(8'h24, 32'h0102_0440);
        wr(8'h20, 32'h44);
        strobe(3'b011, 1'b0);
        strobe(3'b100, 1'b0);
        rd(8'h1c, 32'h7f, 32'h4c, "sticky flags");
        chk_notify(4'b1100);
        strobe(3'b011, 1'b1);
        rd(8'h1c, 32'h7f, 32'h4c, "set beats clear");
        strobe(3'b000, 1'b1);
        rd(8'h1c, 32'h7f, 32'h08, "sticky cleared");
        chk_notify(4'b0000);
        wr(8'h20, 32'h0);
        strobe(3'b011, 1'b0);
        rd(8'h1c, 32'h7f, 32'h4c, "plain flags");
        chk_notify(4'b1100);
        strobe(3'b100, 1'b0);
        rd(8'h1c, 32'h7f, 32'h08, "cleared at packet");
        act_cmd <= 1'b1;
        err_cmd <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(8'h1c, 32'h7f, 32'h0b, "receive flags");
        chk_notify(4'b0011);
        act_cmd <= 1'b0;
        err_cmd <= 1'b0;
        v = $random(seed);
        wr(8'h34, v);
        for (int i = 0; i < 4; i++) begin
            e = $random(seed);
            @(posedge ref_clk);
            {token_strobe, pid_strobe, sof_strobe} <= 3'b111;
            {sof_frame, pid_in, token_endpoint} <= e[18:0];
            @(posedge ref_clk);
            {token_strobe, pid_strobe, sof_strobe} <= 3'b000;
            #1;
            chk("rx endpoint", {27'h0, v[e[3:0]], e[3:0]}, {27'h0, rx_endpoint});
            chk("rx endpoint valid", 32'h1, {31'h0, rx_endpoint_valid});
            rd(8'h30, 32'h1f, {27'h1, e[3:0]}, "last endpoint");
            rd(8'h2c, 32'hf, {28'h0, e[7:4]}, "last pid");
            rd(8'h28, 32'h7ff, {21'h0, e[18:8]}, "frame counter");
        end
        wr(8'h40, 32'h200);
        @(posedge ref_clk);
        line_cmd <= usbif_pkg::LINE_SE0;
        repeat (2) @(posedge ref_clk);
        line_cmd <= usbif_pkg::LINE_J;
        repeat (3) @(posedge ref_clk);
        line_cmd <= usbif_pkg::LINE_K;
        @(posedge ref_clk);
        first = 0;
        for (int i = 1; i <= 12; i++) begin
            @(posedge ref_clk);
            #1;
            if (line_state_filt !== usbif_pkg::LINE_J && first == 0) first = i;
        end
        chk("filter delay ok", 32'h1, {31'h0, first >= 4 && first <= 6});
        chk("filter value", {30'h0, usbif_pkg::LINE_K}, {30'h0, line_state_filt});
        v = 32'h0004_0080 | ((e & 32'h7) << 4);
        wr(8'h40, v);
        line_cmd <= usbif_pkg::LINE_J;
        repeat (2) @(posedge ref_clk);
        #1;
        chk("pins", {27'h0, 2'b11, e[2:0]}, {27'h0, pulldown_disable, suspend_ctl_enable,
                                           transceiver_config_pins});
        line_cmd <= usbif_pkg::LINE_K;
        repeat (4) @(posedge ref_clk);
        rd(8'h40, 32'hffff_ffff, v | 32'h1000, "resume k");
        line_cmd <= usbif_pkg::LINE_SE0;
        repeat (4) @(posedge ref_clk);
        rd(8'h40, 32'hffff_ffff, v | 32'h3000, "resume se0");
        wr(8'h40, v);
        rd(8'h40, 32'hffff_ffff, v, "resume cleared");
        summarize();
    end
endmodule // usb_token_flag_status_block_tb_top
`default_nettype wire

// File: usbif_pkg.sv
// constants and carrier types of the usb interface module status block
// assumes one system clock and a 32-bit peripheral register port
package usbif_pkg;

    localparam logic [7:0]  OFS_EVENT_FLAGS    = 8'h1c;
    localparam logic [7:0]  OFS_STICKINESS     = 8'h20;
    localparam logic [7:0]  OFS_PORT_MASKS     = 8'h24;
    localparam logic [7:0]  OFS_FRAME_COUNTER  = 8'h28;
    localparam logic [7:0]  OFS_LAST_PID       = 8'h2c;
    localparam logic [7:0]  OFS_LAST_ENDPOINT  = 8'h30;
    localparam logic [7:0]  OFS_ENDPOINT_MARKS = 8'h34;
    localparam logic [7:0]  OFS_OTG_MASK       = 8'h38;
    localparam logic [7:0]  OFS_POWER_SIGNAL   = 8'h3c;
    localparam logic [7:0]  OFS_XCVR_CONTROL   = 8'h40;

    localparam int          FLAG_COUNT         = 7;
    localparam int          FLAG_TOKEN_OK      = 6;
    localparam int          FLAG_SE0           = 5;
    localparam int          FLAG_K             = 4;
    localparam int          FLAG_J             = 3;
    localparam int          FLAG_CRC16_FAIL    = 2;
    localparam int          FLAG_RX_ACTIVE     = 1;
    localparam int          FLAG_RX_ERROR      = 0;
    localparam int          FLAG_LEVEL_TOP     = 1;

    localparam int          MASK_N_LSB         = 0;
    localparam int          MASK_O_LSB         = 8;
    localparam int          MASK_P_LSB         = 16;
    localparam int          MASK_Q_LSB         = 24;

    localparam int          EP_VALID_BIT       = 4;
    localparam logic [4:0]  EP_MARK_OR         = 5'h10;

    localparam int          CTL_PULLDOWN_OFF   = 18;
    localparam int          CTL_RESUME_SE0     = 13;
    localparam int          CTL_RESUME_K       = 12;
    localparam int          CTL_FILTER_LSB     = 8;
    localparam int          CTL_SUSPEND_CTL    = 7;
    localparam int          CTL_CONF_LSB       = 4;
    localparam int          POWER_SIGNAL_W     = 9;

    localparam logic [1:0]  LINE_SE0           = 2'h0;
    localparam logic [1:0]  LINE_J             = 2'h1;
    localparam logic [1:0]  LINE_K             = 2'h2;

    localparam logic [31:0] RESET_WORD         = 32'h0000_0000;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } usbif_req_s;

    typedef struct packed {
        logic        rvalid;
        logic [31:0] rdata;
    } usbif_rsp_s;

endpackage : usbif_pkg

// File: usbif_status_block.sv
// flag, mask, frame counter, token capture and transceiver control registers
// assumes one 200 MHz clock, inputs synchronous to it, 32-bit register port
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - sticky bit holds flag until written one
// - notify port high when masked flag high
// - mask bytes map to ports n, o, p, q
// - eleven-bit read/write frame counter, one field in bits 10:0
// - capture last received packet identifier
// - keep copy of last token endpoint
// - valid bit shows endpoint copy is valid
// - marked endpoints delivered ORed with 0x10
// - control bit 18 disables data port pulldowns
// - se0 auto-resume sets bit 13, write clears
// - k auto-resume sets bit 12, write clears
// - line change held off two-to-N plus one clocks
// - bit 7 hands resume to suspend controller
// - bits 6:4 drive transceiver config pins
// - flag order token, se0, k, j, crc, rx
// - non-sticky flags 6:2 clear at next packet, 1:0 follow their inputs
module usbif_status_block (
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,
    input  wire usbif_pkg::usbif_req_s reg_req,
    output var  usbif_pkg::usbif_rsp_s reg_rsp,
    input  wire logic                 packet_start,
    input  wire logic                 token_ok,
    input  wire logic                 crc16_fail,
    input  wire logic                 receive_active_input,
    input  wire logic                 receive_error_input,
    input  wire logic [1:0]           line_state_raw,
    input  wire logic                 pid_strobe,
    input  wire logic [3:0]           pid_in,
    input  wire logic                 token_strobe,
    input  wire logic [3:0]           token_endpoint,
    input  wire logic                 sof_strobe,
    input  wire logic [10:0]          sof_frame,
    input  wire logic                 auto_resume_se0,
    input  wire logic                 auto_resume_k,
    output logic                      notify_port_n,
    output logic                      notify_port_o,
    output logic                      notify_port_p,
    output logic                      notify_port_q,
    output logic [4:0]                rx_endpoint,
    output logic                      rx_endpoint_valid,
    output logic [1:0]                line_state_filt,
    output logic                      pulldown_disable,
    output logic                      suspend_ctl_enable,
    output logic [2:0]                transceiver_config_pins
);

    logic [6:0]  event_flags_q;
    logic [6:0]  flag_stickiness_select_q;
    logic [31:0] port_masks_q;
    logic [10:0] frame_counter_q;
    logic [3:0]  last_pid_q;
    logic [3:0]  last_endpoint_q;
    logic        endpoint_valid_q;
    logic [15:0] endpoint_marks_q;
    logic [31:0] otg_mask_q;
    logic [8:0]  power_signal_q;
    logic        ctl_pulldown_off_q;
    logic        ctl_resume_se0_q;
    logic        ctl_resume_k_q;
    logic [3:0]  ctl_filter_log2_q;
    logic        ctl_suspend_q;
    logic [2:0]  ctl_conf_q;
    logic [1:0]  line_cand_q;
    logic [15:0] line_cnt_q;
    logic [15:0] line_limit;
    logic [6:0]  event_set;
    logic [6:0]  flag_clear;

    function automatic logic wr_at(input logic [7:0] ofs);
        wr_at = reg_req.wr && (reg_req.addr == ofs);
    endfunction

    // line state filter: new level must stay stable for 2^N+1 clocks
    assign line_limit = ~(16'hffff << ctl_filter_log2_q);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            line_cand_q     <= 2'h1;
            line_cnt_q      <= 16'h0000;
            line_state_filt <= 2'h1;
        end else begin
            line_cand_q <= line_state_raw;
            if (line_state_raw != line_cand_q) begin
                line_cnt_q <= 16'h0000;
            end else if (line_cnt_q < line_limit) begin
                line_cnt_q <= line_cnt_q + 16'h0001;
            end else begin
                line_state_filt <= line_cand_q;
            end
        end
    end

    // flag sources, bit 6 down to bit 0
    assign event_set = {token_ok,
                        line_state_filt == usbif_pkg::LINE_SE0,
                        line_state_filt == usbif_pkg::LINE_K,
                        line_state_filt == usbif_pkg::LINE_J,
                        crc16_fail,
                        receive_active_input,
                        receive_error_input};
    assign flag_clear = wr_at(usbif_pkg::OFS_EVENT_FLAGS) ? reg_req.wdata[6:0] : 7'h00;

    generate
        for (genvar i = 0; i < usbif_pkg::FLAG_COUNT; i++) begin : g_flag
            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    event_flags_q[i] <= 1'b0;
                end else if (event_set[i]) begin
                    event_flags_q[i] <= 1'b1;
                end else if (flag_stickiness_select_q[i]) begin
                    if (flag_clear[i]) begin
                        event_flags_q[i] <= 1'b0;
                    end
                end else if (i <= usbif_pkg::FLAG_LEVEL_TOP) begin
                    event_flags_q[i] <= 1'b0;
                end else if (packet_start) begin
                    event_flags_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            notify_port_n <= 1'b0;
            notify_port_o <= 1'b0;
            notify_port_p <= 1'b0;
            notify_port_q <= 1'b0;
        end else begin
            notify_port_n <= |(port_masks_q[usbif_pkg::MASK_N_LSB +: 7] & event_flags_q);
            notify_port_o <= |(port_masks_q[usbif_pkg::MASK_O_LSB +: 7] & event_flags_q);
            notify_port_p <= |(port_masks_q[usbif_pkg::MASK_P_LSB +: 7] & event_flags_q);
            notify_port_q <= |(port_masks_q[usbif_pkg::MASK_Q_LSB +: 7] & event_flags_q);
        end
    end

    // plain software storage
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_stickiness_select_q <= 7'h00;
            port_masks_q             <= usbif_pkg::RESET_WORD;
            endpoint_marks_q         <= 16'h0000;
            otg_mask_q               <= usbif_pkg::RESET_WORD;
            power_signal_q           <= 9'h000;
        end else begin
            if (wr_at(usbif_pkg::OFS_STICKINESS)) begin
                flag_stickiness_select_q <= reg_req.wdata[6:0];
            end
            if (wr_at(usbif_pkg::OFS_PORT_MASKS)) begin
                port_masks_q <= reg_req.wdata;
            end
            if (wr_at(usbif_pkg::OFS_ENDPOINT_MARKS)) begin
                endpoint_marks_q <= reg_req.wdata[15:0];
            end
            if (wr_at(usbif_pkg::OFS_OTG_MASK)) begin
                otg_mask_q <= reg_req.wdata;
            end
            if (wr_at(usbif_pkg::OFS_POWER_SIGNAL)) begin
                power_signal_q <= reg_req.wdata[usbif_pkg::POWER_SIGNAL_W-1:0];
            end
        end
    end

    // frame counter: loaded by received frame numbers, software write wins
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            frame_counter_q <= 11'h000;
        end else if (wr_at(usbif_pkg::OFS_FRAME_COUNTER)) begin
            frame_counter_q <= reg_req.wdata[10:0];
        end else if (sof_strobe) begin
            frame_counter_q <= sof_frame;
        end
    end

    // token capture
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            last_pid_q        <= 4'h0;
            last_endpoint_q   <= 4'h0;
            endpoint_valid_q  <= 1'b0;
            rx_endpoint       <= 5'h00;
            rx_endpoint_valid <= 1'b0;
        end else begin
            rx_endpoint_valid <= token_strobe;
            if (pid_strobe) begin
                last_pid_q <= pid_in;
            end
            if (token_strobe) begin
                last_endpoint_q  <= token_endpoint;
                endpoint_valid_q <= 1'b1;
                rx_endpoint      <= endpoint_marks_q[token_endpoint]
                                  ? ({1'b0, token_endpoint} | usbif_pkg::EP_MARK_OR)
                                  : {1'b0, token_endpoint};
            end
        end
    end

    // transceiver control
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_pulldown_off_q <= 1'b0;
            ctl_resume_se0_q   <= 1'b0;
            ctl_resume_k_q     <= 1'b0;
            ctl_filter_log2_q  <= 4'h0;
            ctl_suspend_q      <= 1'b0;
            ctl_conf_q         <= 3'h0;
        end else begin
            if (wr_at(usbif_pkg::OFS_XCVR_CONTROL)) begin
                ctl_pulldown_off_q <= reg_req.wdata[usbif_pkg::CTL_PULLDOWN_OFF];
                ctl_resume_se0_q   <= reg_req.wdata[usbif_pkg::CTL_RESUME_SE0];
                ctl_resume_k_q     <= reg_req.wdata[usbif_pkg::CTL_RESUME_K];
                ctl_filter_log2_q  <= reg_req.wdata[usbif_pkg::CTL_FILTER_LSB +: 4];
                ctl_suspend_q      <= reg_req.wdata[usbif_pkg::CTL_SUSPEND_CTL];
                ctl_conf_q         <= reg_req.wdata[usbif_pkg::CTL_CONF_LSB +: 3];
            end
            if (auto_resume_se0) begin
                ctl_resume_se0_q <= 1'b1;
            end
            if (auto_resume_k) begin
                ctl_resume_k_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pulldown_disable        <= 1'b0;
            suspend_ctl_enable      <= 1'b0;
            transceiver_config_pins <= 3'h0;
        end else begin
            pulldown_disable        <= ctl_pulldown_off_q;
            suspend_ctl_enable      <= ctl_suspend_q;
            transceiver_config_pins <= ctl_conf_q;
        end
    end

    // read port: one cycle after the request, unmapped offsets read zero
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rsp <= '0;
        end else begin
            reg_rsp.rvalid <= reg_req.rd;
            reg_rsp.rdata  <= usbif_pkg::RESET_WORD;
            if (reg_req.rd) begin
                case (reg_req.addr)
                    usbif_pkg::OFS_EVENT_FLAGS:    reg_rsp.rdata <= {25'h0, event_flags_q};
                    usbif_pkg::OFS_STICKINESS:     reg_rsp.rdata <= {25'h0, flag_stickiness_select_q};
                    usbif_pkg::OFS_PORT_MASKS:     reg_rsp.rdata <= port_masks_q;
                    usbif_pkg::OFS_FRAME_COUNTER:  reg_rsp.rdata <= {21'h0, frame_counter_q};
                    usbif_pkg::OFS_LAST_PID:       reg_rsp.rdata <= {28'h0, last_pid_q};
                    usbif_pkg::OFS_LAST_ENDPOINT:  reg_rsp.rdata <= {27'h0, endpoint_valid_q,
                                                                     last_endpoint_q};
                    usbif_pkg::OFS_ENDPOINT_MARKS: reg_rsp.rdata <= {16'h0, endpoint_marks_q};
                    usbif_pkg::OFS_OTG_MASK:       reg_rsp.rdata <= otg_mask_q;
                    usbif_pkg::OFS_POWER_SIGNAL:   reg_rsp.rdata <= {23'h0, power_signal_q};
                    usbif_pkg::OFS_XCVR_CONTROL:   reg_rsp.rdata <= {13'h0, ctl_pulldown_off_q,
                                                       4'h0, ctl_resume_se0_q, ctl_resume_k_q,
                                                       ctl_filter_log2_q, ctl_suspend_q,
                                                       ctl_conf_q, 4'h0};
                    default:                       reg_rsp.rdata <= usbif_pkg::RESET_WORD;
                endcase
            end
        end
    end

    property p_sticky_hold;
        @(posedge ref_clk) disable iff (!reset_n)
        (flag_stickiness_select_q[usbif_pkg::FLAG_TOKEN_OK] && event_flags_q[6] && !flag_clear[6]
         && $stable(flag_stickiness_select_q)) |=> event_flags_q[6] [*1];
    endproperty
    a_sticky_hold: assert property (p_sticky_hold) else $error("sticky flag lost");
    property p_notify_n;
        @(posedge ref_clk) disable iff (!reset_n)
        ##1 notify_port_n == $past(|(port_masks_q[6:0] & event_flags_q));
    endproperty
    a_notify_n: assert property (p_notify_n) else $error("port n mismatch");
    property p_notify_q;
        @(posedge ref_clk) disable iff (!reset_n)
        (port_masks_q[30:24] == 7'h00) |=> !notify_port_q;
    endproperty
    a_notify_q: assert property (p_notify_q) else $error("port q high without mask");
    property p_frame_write;
        @(posedge ref_clk) disable iff (!reset_n)
        wr_at(usbif_pkg::OFS_FRAME_COUNTER) |=> frame_counter_q == $past(reg_req.wdata[10:0]);
    endproperty
    a_frame_write: assert property (p_frame_write) else $error("frame counter write lost");
    property p_pid_capture;
        @(posedge ref_clk) disable iff (!reset_n)
        pid_strobe |=> last_pid_q == $past(pid_in);
    endproperty
    a_pid_capture: assert property (p_pid_capture) else $error("pid not captured");
    property p_endpoint_mark;
        @(posedge ref_clk) disable iff (!reset_n)
        token_strobe |=> rx_endpoint_valid && rx_endpoint[3:0] == last_endpoint_q
            && rx_endpoint[4] == $past(endpoint_marks_q[token_endpoint]) && endpoint_valid_q;
    endproperty
    a_endpoint_mark: assert property (p_endpoint_mark) else $error("endpoint mark wrong");
    property p_resume_se0;
        @(posedge ref_clk) disable iff (!reset_n)
        auto_resume_se0 |=> ctl_resume_se0_q ##1 (ctl_resume_se0_q || $past(reg_req.wr));
    endproperty
    a_resume_se0: assert property (p_resume_se0) else $error("se0 resume bit not set");
    property p_resume_k;
        @(posedge ref_clk) disable iff (!reset_n)
        auto_resume_k |=> ctl_resume_k_q;
    endproperty
    a_resume_k: assert property (p_resume_k) else $error("k resume bit not set");
    property p_filter_hold;
        @(posedge ref_clk) disable iff (!reset_n)
        (line_state_filt != $past(line_state_filt)) |-> $past(line_cnt_q >= line_limit);
    endproperty
    a_filter_hold: assert property (p_filter_hold) else $error("line change too early");
    property p_conf_pins;
        @(posedge ref_clk) disable iff (!reset_n)
        wr_at(usbif_pkg::OFS_XCVR_CONTROL) |=> ##1 transceiver_config_pins == $past(reg_req.wdata[6:4], 2)
            && pulldown_disable == $past(reg_req.wdata[18], 2);
    endproperty
    a_conf_pins: assert property (p_conf_pins) else $error("config pins wrong");
    property p_packet_clear;
        @(posedge ref_clk) disable iff (!reset_n)
        (packet_start && !flag_stickiness_select_q[2] && !crc16_fail) |=> !event_flags_q[2];
    endproperty
    a_packet_clear: assert property (p_packet_clear) else $error("flag not cleared");
    property p_set_wins;
        @(posedge ref_clk) disable iff (!reset_n)
        (crc16_fail && flag_clear[2]) |=> event_flags_q[2];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

endmodule // usbif_status_block

`default_nettype wire

// File: usbif_xcvr_model.sv
// transceiver side model: line state, receive status and auto-resume pulses
// assumes bench commands change just after rising edges of ref_clk
`timescale 1ns/1ps
`default_nettype none
module usbif_xcvr_model (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       suspend_ctl_enable,
    input  wire logic [1:0] line_cmd,
    input  wire logic       act_cmd,
    input  wire logic       err_cmd,
    output logic [1:0]      line_state_raw,
    output logic            receive_active_input,
    output logic            receive_error_input,
    output logic            auto_resume_se0,
    output logic            auto_resume_k
);
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            line_state_raw       <= usbif_pkg::LINE_J;
            receive_active_input <= 1'b0;
            receive_error_input  <= 1'b0;
            auto_resume_se0      <= 1'b0;
            auto_resume_k        <= 1'b0;
        end else begin
            line_state_raw       <= line_cmd;
            receive_active_input <= act_cmd;
            receive_error_input  <= err_cmd;
            // resume pulses only while the suspend controller owns resume
            auto_resume_se0      <= suspend_ctl_enable && line_cmd == usbif_pkg::LINE_SE0
                                    && line_state_raw != usbif_pkg::LINE_SE0;
            auto_resume_k        <= suspend_ctl_enable && line_cmd == usbif_pkg::LINE_K
                                    && line_state_raw != usbif_pkg::LINE_K;
        end
    end
endmodule // usbif_xcvr_model
`default_nettype wire
